//--- hw/adc_seq_map.svh
// register map, field positions, reset values and timing counts of the converter control
`ifndef ADC_SEQ_MAP_SVH
`define ADC_SEQ_MAP_SVH
// ****************************************
// byte offsets, one aligned word each
// ****************************************
`define OFS_MAIN 8'h00
`define OFS_CLKSRC 8'h04
`define OFS_REF 8'h08
`define OFS_AUTO 8'h0c
`define OFS_INTV 8'h10
`define OFS_RLO 8'h14
`define OFS_RHI 8'h18
`define OFS_IRQ 8'h1c
`define OFS_PBS 8'h20
// ****************************************
// field positions
// ****************************************
`define MAIN_START 7
`define MAIN_PWR 5
`define AUTO_START 7
`define IRQ_FLAG 0
// ****************************************
// reset values and codes
// ****************************************
`define RST_CLKSRC 8'h00
`define RST_AUTO 8'h00
`define SENSOR_CODE 4'hb
`define TRIG_IMMEDIATE 2'h3
// ****************************************
// timing and option memory
// ****************************************
`define SAMPLE_TICKS 4'h4
`define OPT_AMBIENT 14'h3fd3
`define OPT_CONV 14'h3fd4
`define OPT_OFFSET 14'h3fd5
`endif

//--- hw/adc_seq_pkg.sv
// types shared by the converter control and its bench
package adc_seq_pkg;
	// conversion engine states
	typedef enum logic [1:0] {CONV_IDLE, CONV_SAMPLE, CONV_BITS, CONV_GAP} conv_state_t;
	// classic wishbone request
	typedef struct packed {
		logic cyc;
		logic stb;
		logic we;
		logic [7:0] adr;
		logic [3:0] sel;
		logic [31:0] dat;
	} wb_req_t;
	// classic wishbone answer
	typedef struct packed {
		logic ack;
		logic [31:0] dat;
	} wb_rsp_t;
	// controls toward the analog macro
	typedef struct packed {
		logic powerOn;
		logic sensorOn;
		logic sensorRoute;
		logic internalSrc;
		logic [3:0] chan;
		logic [1:0] refSel;
		logic [1:0] gain;
		logic [1:0] ampIn;
		logic [11:0] dacCode;
	} ana_ctrl_t;
endpackage

//--- hw/adc_auto_sequence_control.sv
// converter control: register slave, sar engine, auto sequencer and option memory window
//
// Local design decisions: the placing of the registers and register access over Wishbone.
`include "adc_seq_map.svh"
module adc_auto_sequence_control #(
	parameter logic [7:0] AMBIENT_CODE = 8'h00, // calibration words, written at programming
	parameter logic [11:0] CONV_VALUE = 12'h000,
	parameter logic [7:0] CAL_OFFSET = 8'h00
) (
	// clock and reset
	input wire logic sys_clk,
	input wire logic rst_n,
	// register bus
	input wire adc_seq_pkg::wb_req_t wbReq,
	output adc_seq_pkg::wb_rsp_t wbRsp,
	// analog macro
	output adc_seq_pkg::ana_ctrl_t anaCtrl,
	input wire logic cmpAbove,
	// option memory table read
	input wire logic [13:0] optAddr,
	output logic [15:0] optData,
	// pin function and interrupt
	output logic [7:0] portBFunc,
	output logic convIrq
);
	import adc_seq_pkg::*;

	// ****************************************
	// registers
	// ****************************************
	logic startBit; // manual start pulse bit
	logic powerEn; // converter power
	logic [3:0] inputSel; // channel, sensor code included
	logic [7:0] clkSrc; // clock divide select and source type
	logic [7:0] refCtrl; // reference, gain, amp input
	logic autoStart; // sequence start, cleared by hardware
	logic overrun; // trigger overrun, never set by immediate trigger
	logic [1:0] trigSel;
	logic twoCh; // two channel sequence
	logic [2:0] autoCount; // N
	logic [3:0] interval; // gap in conversion clocks
	logic [3:0] ch2Sel; // second channel of a pair
	logic [15:0] result; // code or accumulated sum
	logic irqFlag;
	logic irqEn;
	logic gie;
	logic temp_sensor_en;
	logic optMap;
	logic ack;
	logic [31:0] rdReg;

	// ****************************************
	// wishbone decode
	// ****************************************
	// ack one cycle after the request; write lands at the acked edge
	wire req = wbReq.cyc & wbReq.stb;
	wire wrEn = req & ack & wbReq.we & wbReq.sel[0];
	wire wrMain = wrEn && wbReq.adr == `OFS_MAIN;
	wire wrClk = wrEn && wbReq.adr == `OFS_CLKSRC;
	wire wrRef = wrEn && wbReq.adr == `OFS_REF;
	wire wrAuto = wrEn && wbReq.adr == `OFS_AUTO;
	wire wrIntv = wrEn && wbReq.adr == `OFS_INTV;
	wire wrIrq = wrEn && wbReq.adr == `OFS_IRQ;
	wire wrPbs = wrEn && wbReq.adr == `OFS_PBS;
	wire [7:0] wd = wbReq.dat[7:0];
	logic busy;
	logic [7:0] rdByte;
	// read mux; unmapped offsets read zero
	always_comb begin
		unique case (wbReq.adr)
			`OFS_MAIN: rdByte = {startBit, busy, powerEn, 1'b0, inputSel};
			`OFS_CLKSRC: rdByte = clkSrc;
			`OFS_REF: rdByte = refCtrl;
			`OFS_AUTO: rdByte = {autoStart, overrun, trigSel, twoCh, autoCount};
			`OFS_INTV: rdByte = {ch2Sel, interval};
			`OFS_RLO: rdByte = result[7:0];
			`OFS_RHI: rdByte = result[15:8];
			`OFS_IRQ: rdByte = {3'h0, optMap, temp_sensor_en, gie, irqEn, irqFlag};
			`OFS_PBS: rdByte = portBFunc;
			default: rdByte = 8'h00;
		endcase
	end
	// answer and registered read data
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			ack <= 1'b0;
			rdReg <= 32'h0000_0000;
		end else begin
			ack <= req & ~ack;
			rdReg <= {24'h00_0000, rdByte};
		end
	end
	assign wbRsp.ack = ack;
	assign wbRsp.dat = rdReg;

	// ****************************************
	// conversion clock divider
	// ****************************************
	// divide by two to the select; select 3 gives the clock over eight
	logic [7:0] divCnt;
	wire [7:0] divTop = 8'((9'h001 << clkSrc[2:0]) - 9'h001);
	wire convTick = divCnt >= divTop;
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) divCnt <= 8'h00;
		else divCnt <= convTick ? 8'h00 : 8'(divCnt + 8'h01);
	end

	// ****************************************
	// sequencer control terms
	// ****************************************
	conv_state_t state;
	logic seqActive; // auto sequence owns the engine
	logic phase2; // converting or waiting for channel two
	logic stopPending; // software stop seen during a conversion
	logic accFirst; // next result loads instead of adding
	logic [2:0] cycleCnt; // completed pairs or singles
	logic convDone; // one-cycle end of conversion
	logic [11:0] code;
	// auto mode works only with immediate trigger and nonzero count
	wire autoOk = trigSel == `TRIG_IMMEDIATE && autoCount != 3'h0 && powerEn;
	// a set while a stopped sequence still finishes its conversion is ignored as well
	wire autoRise = wrAuto && wd[`AUTO_START] && !autoStart && !seqActive && autoOk;
	wire autoClr = wrAuto && !wd[`AUTO_START] && autoStart;
	wire stopNow = autoClr && !busy;
	wire manualGo = wrMain && startBit && !wd[`MAIN_START] && wd[`MAIN_PWR] && !seqActive;
	wire convReset = (wrMain && wd[`MAIN_START]) || !powerEn;
	wire pairEnd = !twoCh || phase2;
	wire [2:0] nextCnt = 3'(cycleCnt + 3'h1);
	wire finish = convDone && seqActive && pairEnd && nextCnt == autoCount;
	wire endSeq = finish || (convDone && stopPending) || stopNow;
	wire gapGo; // gap elapsed, next conversion starts
	wire startConv = autoRise || manualGo || gapGo;

	// ****************************************
	// register writes
	// ****************************************
	// reset values: 20h and 03h are what software loads for manual use
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			{startBit, powerEn, inputSel} <= 6'h00;
			clkSrc <= `RST_CLKSRC;
			refCtrl <= 8'h00;
			{ch2Sel, interval} <= 8'h00;
			{optMap, temp_sensor_en, gie, irqEn} <= 4'h0;
			portBFunc <= 8'h00;
		end else begin
			if (wrMain) {startBit, powerEn, inputSel} <= {wd[7], wd[5], wd[3:0]};
			if (wrClk) clkSrc <= wd;
			if (wrRef) refCtrl <= wd;
			if (wrIntv) {ch2Sel, interval} <= wd;
			if (wrIrq) {optMap, temp_sensor_en, gie, irqEn} <= wd[4:1];
			if (wrPbs) portBFunc <= wd;
		end
	end
	// auto control; a set while running is dropped, hardware clear wins
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			{autoStart, overrun, trigSel, twoCh, autoCount} <= `RST_AUTO;
		end else begin
			if (wrAuto) {trigSel, twoCh, autoCount} <= wd[5:0];
			if (finish || !powerEn) autoStart <= 1'b0;
			else if (autoRise) autoStart <= 1'b1;
			else if (autoClr) autoStart <= 1'b0;
			if (autoRise) overrun <= 1'b0;
		end
	end
	// conversion flag: set wins over the software clear
	wire irqSet = convDone && (!seqActive || finish);
	wire irqClr = wrIrq && !wd[`IRQ_FLAG];
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) irqFlag <= 1'b0;
		else irqFlag <= irqSet | (irqFlag & ~irqClr);
	end
	assign convIrq = irqFlag & irqEn & gie;

	// ****************************************
	// auto sequencer
	// ****************************************
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			seqActive <= 1'b0;
			phase2 <= 1'b0;
			stopPending <= 1'b0;
			cycleCnt <= 3'h0;
		end else if (autoRise) begin
			seqActive <= 1'b1;
			phase2 <= 1'b0;
			stopPending <= 1'b0;
			cycleCnt <= 3'h0;
		end else if (endSeq || !powerEn) begin
			seqActive <= 1'b0;
			phase2 <= 1'b0;
			stopPending <= 1'b0;
			cycleCnt <= 3'h0;
		end else begin
			if (autoClr) stopPending <= 1'b1;
			if (convDone && seqActive) begin
				phase2 <= twoCh && !phase2;
				if (pairEnd) cycleCnt <= nextCnt;
			end
		end
	end

	// ****************************************
	// sar conversion engine
	// ****************************************
	logic [3:0] tickCnt; // sample ticks, then gap ticks
	logic [11:0] trial; // code on the dac
	logic [11:0] mask; // bit under test
	wire [11:0] kept = cmpAbove ? trial : (trial ^ mask);
	wire gapGoInt = state == CONV_GAP && (tickCnt == 4'h0 || (convTick && tickCnt == 4'h1));
	// a sequence that ends this cycle must not relaunch through a zero gap
	assign gapGo = gapGoInt && seqActive && !endSeq;
	assign busy = state == CONV_SAMPLE || state == CONV_BITS;
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			state <= CONV_IDLE;
			tickCnt <= 4'h0;
			trial <= 12'h000;
			mask <= 12'h000;
			convDone <= 1'b0;
		end else begin
			convDone <= 1'b0;
			if (convReset || (state == CONV_GAP && !seqActive)) begin
				state <= CONV_IDLE;
			end else if (startConv) begin
				state <= CONV_SAMPLE;
				tickCnt <= `SAMPLE_TICKS;
			end else begin
				unique case (state)
					CONV_IDLE: begin
						tickCnt <= 4'h0;
					end
					CONV_SAMPLE: if (convTick) begin
						tickCnt <= 4'(tickCnt - 4'h1);
						if (tickCnt == 4'h1) begin
							state <= CONV_BITS;
							trial <= 12'h800;
							mask <= 12'h800;
						end
					end
					CONV_BITS: if (convTick) begin
						mask <= mask >> 1;
						trial <= kept | (mask >> 1);
						if (mask == 12'h001) begin
							convDone <= 1'b1;
							state <= seqActive && !finish && !stopPending ? CONV_GAP : CONV_IDLE;
							tickCnt <= interval;
						end
					end
					CONV_GAP: if (convTick && tickCnt != 4'h0) begin
						tickCnt <= 4'(tickCnt - 4'h1);
					end
				endcase
			end
		end
	end
	assign code = trial; // final code: the last trial after the lsb decision

	// ****************************************
	// result register
	// ****************************************
	// a pair of 12-bit codes over seven cycles stays below 16 bits
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			result <= 16'h0000;
			accFirst <= 1'b1;
		end else if (autoRise) begin
			accFirst <= 1'b1;
		end else if (convDone) begin
			accFirst <= !seqActive;
			if (seqActive && !accFirst) result <= 16'(result + {4'h0, code});
			else result <= {4'h0, code};
		end
	end

	// ****************************************
	// analog controls
	// ****************************************
	wire [3:0] chanNow = seqActive && phase2 ? ch2Sel : inputSel;
	assign anaCtrl.powerOn = powerEn;
	assign anaCtrl.sensorOn = powerEn & temp_sensor_en;
	assign anaCtrl.sensorRoute = chanNow == `SENSOR_CODE;
	assign anaCtrl.internalSrc = clkSrc[4];
	assign anaCtrl.chan = chanNow;
	assign anaCtrl.refSel = refCtrl[7:6];
	assign anaCtrl.gain = refCtrl[3:2];
	assign anaCtrl.ampIn = refCtrl[1:0];
	assign anaCtrl.dacCode = trial;

	// ****************************************
	// option memory window
	// ****************************************
	// offset is signed, low bit one half degree; ambient code in 0.2 degree steps
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) optData <= 16'h0000;
		else if (!optMap) optData <= 16'h0000;
		else if (optAddr == `OPT_AMBIENT) optData <= {8'h00, AMBIENT_CODE};
		else if (optAddr == `OPT_CONV) optData <= {4'h0, CONV_VALUE};
		else if (optAddr == `OPT_OFFSET) optData <= {{8{CAL_OFFSET[7]}}, CAL_OFFSET};
		else optData <= 16'h0000;
	end

	// ****************************************
	// checks
	// ****************************************
	sequence s_startAccepted;
		autoRise;
	endsequence
	sequence s_ch1Running;
		busy && !phase2 && !overrun;
	endsequence
	property p_autoStart;
		@(posedge sys_clk) disable iff (!rst_n) s_startAccepted |=> s_ch1Running;
	endproperty
	a_autoStart: assert property (p_autoStart) else $error("auto start did not begin channel one");
	property p_gapBeforeCh2;
		@(posedge sys_clk) disable iff (!rst_n)
			convDone && seqActive && twoCh && !phase2 && interval != 4'h0 && !stopPending && !gapGo && !autoClr && powerEn
			|=> !busy && phase2;
	endproperty
	a_gapBeforeCh2: assert property (p_gapBeforeCh2) else $error("no gap before channel two");
	property p_finish;
		@(posedge sys_clk) disable iff (!rst_n) finish |=> !autoStart && irqFlag && !seqActive;
	endproperty
	a_finish: assert property (p_finish) else $error("sequence end did not flag");
	property p_flagSticky;
		@(posedge sys_clk) disable iff (!rst_n) irqFlag && !irqClr |=> irqFlag;
	endproperty
	a_flagSticky: assert property (p_flagSticky) else $error("conversion flag lost");
	property p_powerOff;
		@(posedge sys_clk) disable iff (!rst_n) !powerEn |-> !anaCtrl.powerOn ##1 !busy && !seqActive;
	endproperty
	a_powerOff: assert property (p_powerOff) else $error("converter active while powered off");
	property p_doneWhileBusy;
		@(posedge sys_clk) disable iff (!rst_n) convDone |-> $past(busy) && !busy;
	endproperty
	a_doneWhileBusy: assert property (p_doneWhileBusy) else $error("busy not ended at conversion end");
	sequence s_readLow;
		req && !ack && !wbReq.we && wbReq.adr == `OFS_RLO;
	endsequence
	property p_resultLow;
		@(posedge sys_clk) disable iff (!rst_n) s_readLow ##0 !convDone ##1 !convDone |-> wbRsp.dat[7:0] == result[7:0];
	endproperty
	a_resultLow: assert property (p_resultLow) else $error("low result byte misread");
	property p_ignoreSet;
		@(posedge sys_clk) disable iff (!rst_n) seqActive && autoStart && !convDone && !autoClr && powerEn |=> $stable(cycleCnt);
	endproperty
	a_ignoreSet: assert property (p_ignoreSet) else $error("sequence disturbed while running");
	property p_manual;
		@(posedge sys_clk) disable iff (!rst_n) manualGo |=> busy [*2];
	endproperty
	a_manual: assert property (p_manual) else $error("manual start did not convert");
	property p_stopBusy;
		@(posedge sys_clk) disable iff (!rst_n) autoClr && busy && powerEn && !convReset |=> busy || convDone;
	endproperty
	a_stopBusy: assert property (p_stopBusy) else $error("stop cut a conversion short");
endmodule // adc_auto_sequence_control

//--- test/tb_adc_auto_sequence_control.sv
// self-checking bench for the converter control, driven over its register bus
`include "adc_seq_map.svh"
module tb_adc_auto_sequence_control import adc_seq_pkg::*;;
	timeunit 1ns;
	timeprecision 1ns;
	// ****************************************
	// signals and counters
	// ****************************************
	logic sys_clk; // 100 ns period
	logic rst_n; // async, active low
	wb_req_t wbReq; // bus request from the bench
	wb_rsp_t wbRsp; // bus answer
	ana_ctrl_t anaCtrl; // controls toward the analog macro
	logic cmpAbove; // comparator level fed back
	logic [13:0] optAddr; // table-read address
	logic [15:0] optData; // table-read data
	logic [7:0] portBFunc; // pin function register
	logic convIrq; // gated interrupt request
	logic [7:0] q; // last read byte
	logic sawCh2; // second channel seen on the selector
	int failCount; // mismatches
	int nTests; // comparisons made
	int cycles; // hang guard
	// calibration words: arbitrary values, chosen so each byte is distinct
	localparam logic [7:0] AMB = 8'h5a;
	localparam logic [11:0] CONV = 12'h09c3;
	localparam logic [7:0] OFFS = 8'hf3;
	localparam logic [13:0] OPT_ADR [3] = '{`OPT_AMBIENT, `OPT_CONV, `OPT_OFFSET};
	localparam logic [15:0] OPT_EXP [3] = '{{8'h00, AMB}, {4'h0, CONV}, {8'hff, OFFS}};
	// ****************************************
	// design under test
	// ****************************************
	adc_auto_sequence_control #(.AMBIENT_CODE(AMB), .CONV_VALUE(CONV), .CAL_OFFSET(OFFS)) dut (
		.sys_clk(sys_clk),
		.rst_n(rst_n),
		.wbReq(wbReq),
		.wbRsp(wbRsp),
		.anaCtrl(anaCtrl),
		.cmpAbove(cmpAbove),
		.optAddr(optAddr),
		.optData(optData),
		.portBFunc(portBFunc),
		.convIrq(convIrq)
	);
	// clock: toggle every half period
	always #50 sys_clk = ~sys_clk;
	// note any cycle where the selector shows the second channel
	always @(posedge sys_clk) begin
		if (anaCtrl.chan === 4'h5) begin
			sawCh2 <= 1'b1;
		end
	end
	// hang guard: far above the one to two thousand cycles the tests need
	always @(posedge sys_clk) begin
		cycles++;
		if (cycles == 30000) begin
			failCount++;
			complete_run();
		end
	end
	// ****************************************
	// tasks
	// ****************************************
	// verdict and end of run
	task automatic complete_run();
		$display("checks %0d, mismatches %0d", nTests, failCount);
		if (failCount == 0 && nTests > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask
	// one compare, counted
	task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
		nTests++;
		if (seen !== exp) begin
			failCount++;
			$display("FAIL %s expected %h seen %h", what, exp, seen);
		end
	endtask
	// classic single cycle; request held until ack is sampled high
	task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] d, output logic [7:0] r);
		@(posedge sys_clk);
		wbReq <= '{1'b1, 1'b1, w, a, 4'h1, {24'h00_0000, d}};
		@(posedge sys_clk);
		while (wbRsp.ack !== 1'b1) begin
			@(posedge sys_clk);
		end
		r = wbRsp.dat[7:0];
		wbReq <= '0;
	endtask
	// write, then let the register update land
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		logic [7:0] r;
		xfer(1'b1, a, d, r);
		@(posedge sys_clk);
	endtask
	// read one byte
	task automatic rd(input logic [7:0] a);
		xfer(1'b0, a, 8'h00, q);
	endtask
	// poll a bit until it reaches a level; bounded number of reads
	task automatic waitBit(input logic [7:0] a, input int b, input logic v);
		int k;
		k = 0;
		rd(a);
		while (q[b] !== v && k < 500) begin
			rd(a);
			k++;
		end
	endtask
	// read back the two result bytes
	task automatic checkResult(input logic [15:0] exp);
		rd(`OFS_RLO);
		check("result low", {8'h00, q}, {8'h00, exp[7:0]});
		rd(`OFS_RHI);
		check("result high", {8'h00, q}, {8'h00, exp[15:8]});
	endtask
	// ****************************************
	// main sequence
	// ****************************************
	initial begin
		sys_clk = 1'b0;
		rst_n = 1'b0;
		wbReq = '0;
		cmpAbove = 1'b1;
		optAddr = 14'h0000;
		sawCh2 = 1'b0;
		repeat (12) @(posedge sys_clk);
		rst_n <= 1'b1;
		// reset values, and an unmapped place that ignores writes
		rd(`OFS_MAIN);
		check("main reset", {8'h00, q}, 16'h0000);
		rd(`OFS_AUTO);
		check("auto reset", {8'h00, q}, {8'h00, `RST_AUTO});
		wr(8'h40, 8'hff);
		rd(8'h40);
		check("unmapped", {8'h00, q}, 16'h0000);
		$display("test reset done");
		// manual setup as software would do it
		wr(`OFS_AUTO, 8'h00);
		wr(`OFS_CLKSRC, 8'h03);
		wr(`OFS_REF, 8'h00);
		wr(`OFS_PBS, 8'h03);
		wr(`OFS_MAIN, 8'h20);
		rd(`OFS_CLKSRC);
		check("clock ctrl", {8'h00, q}, 16'h0003);
		check("power on", {15'h0000, anaCtrl.powerOn}, 16'h0001);
		check("channel", {12'h000, anaCtrl.chan}, 16'h0000);
		check("internal src", {15'h0000, anaCtrl.internalSrc}, 16'h0000);
		check("ref sel", {14'h0000, anaCtrl.refSel}, 16'h0000);
		// settling time after power up before the first conversion
		repeat (20) @(posedge sys_clk);
		check("pin func", {8'h00, portBFunc}, 16'h0003);
		$display("test setup done");
		// manual conversions at both ends of the code range
		for (int i = 0; i < 2; i++) begin
			cmpAbove <= (i == 0);
			wr(`OFS_MAIN, 8'ha0);
			wr(`OFS_MAIN, 8'h20);
			rd(`OFS_MAIN);
			check("busy", {15'h0000, q[6]}, 16'h0001);
			waitBit(`OFS_MAIN, 6, 1'b0);
			check("busy end", {15'h0000, q[6]}, 16'h0000);
			checkResult((i == 0) ? 16'h0fff : 16'h0000);
			check("dac code", {4'h0, anaCtrl.dacCode}, (i == 0) ? 16'h0fff : 16'h0000);
			rd(`OFS_IRQ);
			check("flag", {15'h0000, q[0]}, 16'h0001);
		end
		check("irq gated", {15'h0000, convIrq}, 16'h0000);
		wr(`OFS_IRQ, 8'h07);
		check("irq on", {15'h0000, convIrq}, 16'h0001);
		wr(`OFS_IRQ, 8'h06);
		check("irq cleared", {15'h0000, convIrq}, 16'h0000);
		$display("test manual done");
		// a zero count must not start a sequence
		wr(`OFS_AUTO, 8'hb8);
		rd(`OFS_AUTO);
		check("count zero", {15'h0000, q[7]}, 16'h0000);
		// two-channel auto sequence, N = 2, gap 2, second channel 5
		cmpAbove <= 1'b1;
		sawCh2 <= 1'b0;
		wr(`OFS_INTV, 8'h52);
		wr(`OFS_AUTO, 8'hba);
		rd(`OFS_AUTO);
		check("overrun clear", {15'h0000, q[6]}, 16'h0000);
		wr(`OFS_AUTO, 8'hba);
		waitBit(`OFS_AUTO, 7, 1'b0);
		check("auto stop", {15'h0000, q[7]}, 16'h0000);
		check("second channel", {15'h0000, sawCh2}, 16'h0001);
		checkResult(16'h3ffc);
		rd(`OFS_IRQ);
		check("auto flag", {15'h0000, q[0]}, 16'h0001);
		check("auto irq", {15'h0000, convIrq}, 16'h0001);
		$display("test auto done");
		// stop in mid-conversion: current one finishes, no flag
		wr(`OFS_IRQ, 8'h06);
		wr(`OFS_AUTO, 8'hbf);
		waitBit(`OFS_MAIN, 6, 1'b1);
		wr(`OFS_AUTO, 8'h3f);
		rd(`OFS_MAIN);
		check("still busy", {15'h0000, q[6]}, 16'h0001);
		waitBit(`OFS_MAIN, 6, 1'b0);
		rd(`OFS_AUTO);
		check("stopped", {15'h0000, q[7]}, 16'h0000);
		rd(`OFS_IRQ);
		check("no flag", {15'h0000, q[0]}, 16'h0000);
		checkResult(16'h0fff);
		$display("test abort done");
		// sensor routing, option window off then on, power down
		wr(`OFS_CLKSRC, 8'h06);
		wr(`OFS_REF, 8'h85);
		check("sensor ref", {10'h000, anaCtrl.refSel, anaCtrl.gain, anaCtrl.ampIn}, 16'h0025);
		wr(`OFS_IRQ, 8'h0e);
		wr(`OFS_MAIN, 8'h2b);
		check("sensor route", {15'h0000, anaCtrl.sensorRoute}, 16'h0001);
		check("sensor chan", {12'h000, anaCtrl.chan}, {12'h000, `SENSOR_CODE});
		check("sensor on", {15'h0000, anaCtrl.sensorOn}, 16'h0001);
		// sensor settling time before it may be converted
		repeat (20) @(posedge sys_clk);
		for (int m = 0; m < 2; m++) begin
			if (m == 1) begin
				wr(`OFS_IRQ, 8'h1e);
			end
			for (int k = 0; k < 3; k++) begin
				optAddr <= OPT_ADR[k];
				repeat (2) @(posedge sys_clk);
				check("option word", optData, (m == 1) ? OPT_EXP[k] : 16'h0000);
			end
		end
		wr(`OFS_MAIN, 8'h00);
		check("power off", {15'h0000, anaCtrl.powerOn}, 16'h0000);
		check("sensor off", {15'h0000, anaCtrl.sensorOn}, 16'h0000);
		$display("test sensor done");
		complete_run();
	end
endmodule // tb_adc_auto_sequence_control
